// file: tf_cfg.svh
`ifndef TF_CFG_SVH
`define TF_CFG_SVH

`define TF_NUM_SEG 23
`define TF_IDX_W 5
`define TF_X_W 15
`define TF_Y_W 25
`define TF_MAG_W 24
`define TF_DIGITS 7
`define TF_DIG_LAST 3'h6
`define TF_DIV_LAST 6'h28
`define TF_FMT_LAST 5'h17
`define TF_PT_HIGH 5'h18
`define TF_Y_LIMIT 24'h98967F
`define TF_X_LO_RST 15'h0000
`define TF_X_HI_RST 15'h7FFF
`define TF_Y_LO_RST 25'h0000000
`define TF_Y_HI_RST 25'h0007FFF
`define TF_CH_PLUS 8'h2B
`define TF_CH_MINUS 8'h2D
`define TF_CH_POINT 8'h2E
`define TF_CH_ZERO 8'h30

`endif

// file: tf_pkg.sv
`default_nettype none

package tf_pkg;
    typedef enum logic [2:0] {
        write_enable_cmd = 3'b000,
        set_low_endpoint_cmd = 3'b001,
        set_high_endpoint_cmd = 3'b010,
        set_segment_point_cmd = 3'b011,
        erase_segment_points_cmd = 3'b100,
        clear_offset_cmd = 3'b101
    } cmd_e;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_parse = 3'b001,
        st_scan = 3'b010,
        st_div = 3'b011,
        st_fmt = 3'b100
    } state_e;
endpackage : tf_pkg

`default_nettype wire

// file: tf_text_fmt.sv
`include "tf_cfg.svh"
`default_nettype none

module tf_text_fmt (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic neg_i,
    input wire logic [`TF_MAG_W-1:0] mag_i,
    output logic done_o,
    output logic [71:0] text_o
);
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic neg_q, neg_d;
    logic [4:0] cnt_q, cnt_d;
    logic [`TF_MAG_W-1:0] bin_q, bin_d;
    logic [27:0] bcd_q, bcd_d;
    logic [71:0] text_q, text_d;
    logic [27:0] adj;

    // Double dabble: one bit per cycle keeps the adder count at seven nibbles
    always_comb
    begin
        busy_d = busy_q;
        done_d = 1'b0;
        neg_d = neg_q;
        cnt_d = cnt_q;
        bin_d = bin_q;
        bcd_d = bcd_q;
        text_d = text_q;
        adj = bcd_q;
        for (int i = 0; i < `TF_DIGITS; i++)
        begin
            if (bcd_q[4*i +: 4] > 4'h4)
            begin
                adj[4*i +: 4] = bcd_q[4*i +: 4] + 4'h3;
            end
        end
        if (start_i && !busy_q)
        begin
            busy_d = 1'b1;
            neg_d = neg_i;
            bin_d = mag_i;
            bcd_d = 28'h0000000;
            cnt_d = 5'h00;
        end
        else if (busy_q)
        begin
            bcd_d = {adj[26:0], bin_q[`TF_MAG_W-1]};
            bin_d = {bin_q[`TF_MAG_W-2:0], 1'b0};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == `TF_FMT_LAST)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
                // Sign, five digits, point, two digits
                text_d = {(neg_q ? `TF_CH_MINUS : `TF_CH_PLUS),
                    `TF_CH_ZERO | {4'h0, bcd_d[27:24]},
                    `TF_CH_ZERO | {4'h0, bcd_d[23:20]},
                    `TF_CH_ZERO | {4'h0, bcd_d[19:16]},
                    `TF_CH_ZERO | {4'h0, bcd_d[15:12]},
                    `TF_CH_ZERO | {4'h0, bcd_d[11:8]},
                    `TF_CH_POINT,
                    `TF_CH_ZERO | {4'h0, bcd_d[7:4]},
                    `TF_CH_ZERO | {4'h0, bcd_d[3:0]}};
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            neg_q <= 1'b0;
            cnt_q <= 5'h00;
            bin_q <= '0;
            bcd_q <= 28'h0000000;
            text_q <= {`TF_CH_PLUS, {5{`TF_CH_ZERO}}, `TF_CH_POINT,
                {2{`TF_CH_ZERO}}};
        end
        else
        begin
            busy_q <= busy_d;
            done_q <= done_d;
            neg_q <= neg_d;
            cnt_q <= cnt_d;
            bin_q <= bin_d;
            bcd_q <= bcd_d;
            text_q <= text_d;
        end
    end

    assign done_o = done_q;
    assign text_o = text_q;
endmodule : tf_text_fmt

`default_nettype wire

// file: transfer_function_programmer.sv
// Summary of operation
// - Readings leave as sign, 5 digits, point, 2
// - Low command captures live converter sample as X
// - Low command parses signed argument as Y
// - New low point used at once
// - Point commands overwrite their entry completely
// - High and segment commands capture X, Y alike
// - Protected commands need a preceding write enable
// - Erase removes every segment point
// - Erase keeps both endpoints
// - Converter samples are 15 bits, 32768 counts
// - Reading outside endpoint span reports overload
// - Clear-offset command zeroes the offset register
// - Only digital scaling, no analog controls
`include "tf_cfg.svh"
`default_nettype none

module transfer_function_programmer #(
    parameter int NUM_SEG = `TF_NUM_SEG
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_code_i,
    input wire logic [`TF_IDX_W-1:0] cmd_index_i,
    input wire logic cmd_arg_neg_i,
    input wire logic [27:0] cmd_arg_bcd_i,
    input wire logic adc_valid_i,
    input wire logic [`TF_X_W-1:0] adc_data_i,
    input wire logic offset_load_i,
    input wire logic [`TF_Y_W-1:0] offset_val_i,
    output logic cmd_ready_o,
    output logic cmd_done_o,
    output logic cmd_refused_o,
    output logic reading_valid_o,
    output logic [71:0] reading_text_o,
    output logic overload_o
);
    tf_pkg::state_e state_q, state_d;
    tf_pkg::cmd_e cmd_q, cmd_d;
    logic we_q, we_d;
    logic done_q, done_d;
    logic ref_q, ref_d;
    logic ovl_q, ovl_d;
    logic pend_q, pend_d;
    logic neg_q, neg_d;
    logic [`TF_IDX_W-1:0] idx_q, idx_d, k_q, k_d;
    logic [27:0] arg_q, arg_d;
    logic [`TF_MAG_W-1:0] acc_q, acc_d;
    logic [5:0] cnt_q, cnt_d;
    // X values are raw 15-bit samples, 32768 counts
    logic [`TF_X_W-1:0] adc_q, adc_d, xcap_q, xcap_d, x_q, x_d;
    logic [`TF_X_W-1:0] x_lo_q, x_lo_d, x_hi_q, x_hi_d;
    logic [`TF_Y_W-1:0] y_lo_q, y_lo_d, y_hi_q, y_hi_d, ofs_q, ofs_d;
    logic [`TF_Y_W-1:0] ya_q, ya_d;
    logic [15:0] rem_q, rem_d, dvsr_q, dvsr_d;
    logic [40:0] dvd_q, dvd_d;
    logic qneg_q, qneg_d;
    logic [`TF_X_W-1:0] seg_x_q [NUM_SEG];
    logic [`TF_X_W-1:0] seg_x_d [NUM_SEG];
    logic [`TF_Y_W-1:0] seg_y_q [NUM_SEG];
    logic [`TF_Y_W-1:0] seg_y_d [NUM_SEG];
    logic [NUM_SEG-1:0] seg_ok_q, seg_ok_d;
    logic seg_wr, erase_all, fmt_start, fmt_neg, fmt_done;
    logic [`TF_MAG_W-1:0] fmt_mag, acc_n;
    logic [`TF_Y_W-1:0] y_new;
    logic [`TF_IDX_W-1:0] nxt;
    logic [`TF_X_W-1:0] xa, xb;
    logic [`TF_Y_W-1:0] yb;
    logic [25:0] dy;
    logic [25:0] dy_mag;
    logic [16:0] rem_n;
    logic [40:0] dvd_n;
    logic [27:0] sum;
    logic [27:0] sum_mag;

    // Point list: 0 is the low end, 1..NUM_SEG segment points, then high
    always_comb
    begin
        xa = (k_q == 5'h00) ? x_lo_q : seg_x_q[k_q - 5'h01];
        nxt = `TF_PT_HIGH;
        if (k_q < 5'(NUM_SEG) && seg_ok_q[k_q])
        begin
            nxt = k_q + 5'h01;
        end
        xb = (nxt == `TF_PT_HIGH) ? x_hi_q : seg_x_q[nxt - 5'h01];
        yb = (nxt == `TF_PT_HIGH) ? y_hi_q : seg_y_q[nxt - 5'h01];
    end

    always_comb
    begin
        state_d = state_q;
        cmd_d = cmd_q;
        we_d = we_q;
        done_d = 1'b0;
        ref_d = 1'b0;
        ovl_d = ovl_q;
        pend_d = pend_q;
        neg_d = neg_q;
        idx_d = idx_q;
        k_d = k_q;
        arg_d = arg_q;
        acc_d = acc_q;
        cnt_d = cnt_q;
        adc_d = adc_q;
        xcap_d = xcap_q;
        x_d = x_q;
        x_lo_d = x_lo_q;
        x_hi_d = x_hi_q;
        y_lo_d = y_lo_q;
        y_hi_d = y_hi_q;
        ofs_d = ofs_q;
        ya_d = ya_q;
        rem_d = rem_q;
        dvsr_d = dvsr_q;
        dvd_d = dvd_q;
        qneg_d = qneg_q;
        seg_wr = 1'b0;
        erase_all = 1'b0;
        fmt_start = 1'b0;
        fmt_neg = 1'b0;
        fmt_mag = '0;
        acc_n = 24'((acc_q << 3) + (acc_q << 1) + {20'h00000, arg_q[27:24]});
        y_new = neg_q ? -{1'b0, acc_n} : {1'b0, acc_n};
        dy = 26'({yb[24], yb} - {ya_q[24], ya_q});
        dy_mag = dy[25] ? -dy : dy;
        rem_n = {rem_q, dvd_q[40]};
        dvd_n = {dvd_q[39:0], 1'b0};
        if (rem_n >= {1'b0, dvsr_q})
        begin
            rem_n = rem_n - {1'b0, dvsr_q};
            dvd_n[0] = 1'b1;
        end
        sum = 28'({{3{ya_q[24]}}, ya_q} + {{3{ofs_q[24]}}, ofs_q}
            + (qneg_q ? -{2'b00, dvd_n[25:0]} : {2'b00, dvd_n[25:0]}));
        sum_mag = sum[27] ? -sum : sum;
        if (adc_valid_i)
        begin
            adc_d = adc_data_i;
            pend_d = 1'b1;
        end
        if (offset_load_i)
        begin
            ofs_d = offset_val_i;
        end
        unique case (state_q)
            tf_pkg::st_idle:
            begin
                if (cmd_valid_i)
                begin
                    cmd_d = tf_pkg::cmd_e'(cmd_code_i);
                    idx_d = cmd_index_i;
                    neg_d = cmd_arg_neg_i;
                    arg_d = cmd_arg_bcd_i;
                    acc_d = '0;
                    cnt_d = 6'h00;
                    xcap_d = adc_q;
                    we_d = 1'b0;
                    if (cmd_code_i == tf_pkg::write_enable_cmd)
                    begin
                        we_d = 1'b1;
                        done_d = 1'b1;
                    end
                    else if (!we_q || cmd_code_i > tf_pkg::clear_offset_cmd
                        || (cmd_code_i == tf_pkg::set_segment_point_cmd
                        && cmd_index_i >= 5'(NUM_SEG)))
                    begin
                        ref_d = 1'b1;
                    end
                    else if (cmd_code_i == tf_pkg::erase_segment_points_cmd)
                    begin
                        erase_all = 1'b1;
                        done_d = 1'b1;
                    end
                    else if (cmd_code_i == tf_pkg::clear_offset_cmd)
                    begin
                        ofs_d = '0;
                        done_d = 1'b1;
                    end
                    else
                    begin
                        state_d = tf_pkg::st_parse;
                    end
                end
                else if (pend_q)
                begin
                    pend_d = adc_valid_i;
                    x_d = adc_q;
                    k_d = 5'h00;
                    // Overload reads as the limit with its sign
                    if (adc_q < x_lo_q || adc_q > x_hi_q)
                    begin
                        ovl_d = 1'b1;
                        fmt_start = 1'b1;
                        fmt_neg = adc_q < x_lo_q;
                        fmt_mag = `TF_Y_LIMIT;
                        state_d = tf_pkg::st_fmt;
                    end
                    else
                    begin
                        ovl_d = 1'b0;
                        ya_d = y_lo_q;
                        state_d = tf_pkg::st_scan;
                    end
                end
            end
            tf_pkg::st_parse:
            begin
                // Argument digits arrive most significant first
                acc_d = acc_n;
                arg_d = {arg_q[23:0], 4'h0};
                cnt_d = cnt_q + 6'h01;
                if (cnt_q[2:0] == `TF_DIG_LAST)
                begin
                    state_d = tf_pkg::st_idle;
                    done_d = 1'b1;
                    // Stored pair replaces the old one outright
                    unique case (cmd_q)
                        tf_pkg::set_low_endpoint_cmd:
                        begin
                            x_lo_d = xcap_q;
                            y_lo_d = y_new;
                        end
                        tf_pkg::set_high_endpoint_cmd:
                        begin
                            x_hi_d = xcap_q;
                            y_hi_d = y_new;
                        end
                        default:
                        begin
                            seg_wr = 1'b1;
                        end
                    endcase
                end
            end
            tf_pkg::st_scan:
            begin
                // Table is read live, so fresh points apply at once
                if (x_q <= xb)
                begin
                    dvsr_d = {1'b0, xb - xa};
                    // Both factors at full width so no product bit is lost
                    dvd_d = {15'h0000, dy_mag}
                        * {26'h0000000, x_q - xa};
                    qneg_d = dy[25];
                    rem_d = 16'h0000;
                    cnt_d = 6'h00;
                    if (xb == xa)
                    begin
                        dvd_d = '0;
                        dvsr_d = 16'h0001;
                    end
                    state_d = tf_pkg::st_div;
                end
                else
                begin
                    k_d = nxt;
                    ya_d = yb;
                end
            end
            tf_pkg::st_div:
            begin
                rem_d = rem_n[15:0];
                dvd_d = dvd_n;
                cnt_d = cnt_q + 6'h01;
                if (cnt_q == `TF_DIV_LAST)
                begin
                    fmt_start = 1'b1;
                    fmt_neg = sum[27];
                    fmt_mag = (sum_mag[26:0] > {3'h0, `TF_Y_LIMIT}) ?
                        `TF_Y_LIMIT : sum_mag[23:0];
                    state_d = tf_pkg::st_fmt;
                end
            end
            tf_pkg::st_fmt:
            begin
                if (fmt_done)
                begin
                    state_d = tf_pkg::st_idle;
                end
            end
            default:
            begin
                state_d = tf_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= tf_pkg::st_idle;
            cmd_q <= tf_pkg::write_enable_cmd;
            {we_q, done_q, ref_q, ovl_q, pend_q, neg_q, qneg_q} <= 7'h00;
            idx_q <= '0;
            k_q <= '0;
            arg_q <= '0;
            acc_q <= '0;
            cnt_q <= 6'h00;
            adc_q <= '0;
            xcap_q <= '0;
            x_q <= '0;
            x_lo_q <= `TF_X_LO_RST;
            x_hi_q <= `TF_X_HI_RST;
            y_lo_q <= `TF_Y_LO_RST;
            y_hi_q <= `TF_Y_HI_RST;
            ofs_q <= '0;
            ya_q <= '0;
            rem_q <= 16'h0000;
            dvsr_q <= 16'h0001;
            dvd_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            {we_q, done_q, ref_q, ovl_q, pend_q, neg_q, qneg_q} <=
                {we_d, done_d, ref_d, ovl_d, pend_d, neg_d, qneg_d};
            idx_q <= idx_d;
            k_q <= k_d;
            arg_q <= arg_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            adc_q <= adc_d;
            xcap_q <= xcap_d;
            x_q <= x_d;
            x_lo_q <= x_lo_d;
            x_hi_q <= x_hi_d;
            y_lo_q <= y_lo_d;
            y_hi_q <= y_hi_d;
            ofs_q <= ofs_d;
            ya_q <= ya_d;
            rem_q <= rem_d;
            dvsr_q <= dvsr_d;
            dvd_q <= dvd_d;
        end
    end

    // Gain and offset of the analog path have no control here
    for (genvar g = 0; g < NUM_SEG; g++)
    begin : g_seg
        always_comb
        begin
            seg_x_d[g] = seg_x_q[g];
            seg_y_d[g] = seg_y_q[g];
            seg_ok_d[g] = seg_ok_q[g] & ~erase_all;
            if (seg_wr && idx_q == 5'(g))
            begin
                seg_x_d[g] = xcap_q;
                seg_y_d[g] = y_new;
                seg_ok_d[g] = 1'b1;
            end
        end

        always_ff @(posedge clock_i)
        begin
            if (sys_rst_i)
            begin
                seg_x_q[g] <= '0;
                seg_y_q[g] <= '0;
                seg_ok_q[g] <= 1'b0;
            end
            else
            begin
                seg_x_q[g] <= seg_x_d[g];
                seg_y_q[g] <= seg_y_d[g];
                seg_ok_q[g] <= seg_ok_d[g];
            end
        end
    end

    tf_text_fmt u_fmt (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .start_i(fmt_start),
        .neg_i(fmt_neg),
        .mag_i(fmt_mag),
        .done_o(fmt_done),
        .text_o(reading_text_o)
    );

    assign cmd_ready_o = state_q == tf_pkg::st_idle;
    assign cmd_done_o = done_q;
    assign cmd_refused_o = ref_q;
    assign reading_valid_o = fmt_done;
    assign overload_o = ovl_q;

    AST_TEXT_LAYOUT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        reading_valid_o |-> reading_text_o[23:16] == `TF_CH_POINT
        && (reading_text_o[71:64] == `TF_CH_PLUS
        || reading_text_o[71:64] == `TF_CH_MINUS))
        else $error("reading text layout wrong");
    AST_LOW_X: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_ready_o && cmd_valid_i && we_q
        && cmd_code_i == tf_pkg::set_low_endpoint_cmd
        |-> ##8 x_lo_q == $past(adc_q, 8))
        else $error("low X not the captured sample");
    AST_LOW_Y_SIGN: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_ready_o && cmd_valid_i && we_q && cmd_arg_bcd_i != 28'h0
        && cmd_code_i == tf_pkg::set_low_endpoint_cmd
        |-> ##8 y_lo_q[24] == $past(cmd_arg_neg_i, 8))
        else $error("low Y sign wrong");
    AST_HIGH_X: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_ready_o && cmd_valid_i && we_q
        && cmd_code_i == tf_pkg::set_high_endpoint_cmd
        |-> ##8 x_hi_q == $past(adc_q, 8) && cmd_done_o)
        else $error("high X not the captured sample");
    AST_NEED_WE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_ready_o && cmd_valid_i && !we_q
        && cmd_code_i != tf_pkg::write_enable_cmd
        |=> cmd_refused_o && !cmd_done_o && $stable(x_lo_q))
        else $error("protected command not refused");
    AST_ERASE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_ready_o && cmd_valid_i && we_q
        && cmd_code_i == tf_pkg::erase_segment_points_cmd
        |=> seg_ok_q == '0)
        else $error("erase left segment points");
    AST_ERASE_KEEP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        erase_all |=> $stable(x_lo_q) && $stable(x_hi_q)
        && $stable(y_lo_q) && $stable(y_hi_q))
        else $error("erase touched endpoints");
    AST_OVERLOAD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_ready_o && !cmd_valid_i && pend_q && adc_q > x_hi_q
        |=> overload_o ##[1:30] reading_valid_o)
        else $error("overload not reported");
    AST_CLEAR_OFS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_ready_o && cmd_valid_i && we_q && !offset_load_i
        && cmd_code_i == tf_pkg::clear_offset_cmd |=> ofs_q == '0)
        else $error("offset not cleared");
    AST_INTERP_ENDS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state_q == tf_pkg::st_scan |-> ##[1:100] reading_valid_o)
        else $error("interpolation did not finish");
endmodule : transfer_function_programmer

`default_nettype wire

// file: host_model.sv
`default_nettype none

module host_model (
    input wire logic clock_i,
    input wire logic cmd_ready_i,
    input wire logic cmd_done_i,
    input wire logic cmd_refused_i,
    output logic cmd_valid_o,
    output logic [2:0] cmd_code_o,
    output logic [4:0] cmd_index_o,
    output logic cmd_arg_neg_o,
    output logic [27:0] cmd_arg_bcd_o,
    output logic adc_valid_o,
    output logic [14:0] adc_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 3'h7;
        cmd_index_o = 5'h1F;
        cmd_arg_neg_o = 1'b1;
        cmd_arg_bcd_o = 28'hFFFFFFF;
        adc_valid_o = 1'b0;
        adc_data_o = 15'h7FFF;
    end

    // Known stimulus, always within 15-bit full scale
    task automatic sample(input logic [14:0] x);
        @(posedge clock_i);
        adc_valid_o <= 1'b1;
        adc_data_o <= x;
        @(posedge clock_i);
        adc_valid_o <= 1'b0;
        adc_data_o <= ~x;
    endtask : sample

    // Unqualified fields go to inverted junk so stale values never pass
    task automatic send(input logic [2:0] c, input logic [4:0] i,
        input logic n, input logic [27:0] b, output int cyc,
        output logic refd);
        int k;
        @(posedge clock_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= c;
        cmd_index_o <= i;
        cmd_arg_neg_o <= n;
        cmd_arg_bcd_o <= b;
        k = 0;
        do
        begin
            @(posedge clock_i);
            k++;
        end
        while (cmd_ready_i !== 1'b1 && k < 300);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~c;
        cmd_index_o <= ~i;
        cmd_arg_neg_o <= ~n;
        cmd_arg_bcd_o <= ~b;
        cyc = 0;
        while (cyc < 20 && cmd_done_i !== 1'b1 && cmd_refused_i !== 1'b1)
        begin
            @(posedge clock_i);
            cyc++;
        end
        refd = (cmd_refused_i === 1'b1);
    endtask : send
endmodule : host_model

`default_nettype wire

// file: transfer_function_programmer_tb_top.sv
`default_nettype none

module transfer_function_programmer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_i = 1'b0;
    logic sys_rst_i;
    logic cmd_valid_i;
    logic [2:0] cmd_code_i;
    logic [4:0] cmd_index_i;
    logic cmd_arg_neg_i;
    logic [27:0] cmd_arg_bcd_i;
    logic adc_valid_i;
    logic [14:0] adc_data_i;
    logic offset_load_i;
    logic [24:0] offset_val_i;
    logic cmd_ready_o;
    logic cmd_done_o;
    logic cmd_refused_o;
    logic reading_valid_o;
    logic [71:0] reading_text_o;
    logic overload_o;
    int num_errors = 0;
    int num_checks = 0;

    transfer_function_programmer #(.NUM_SEG(23)) DUT (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
        .cmd_index_i(cmd_index_i), .cmd_arg_neg_i(cmd_arg_neg_i),
        .cmd_arg_bcd_i(cmd_arg_bcd_i), .adc_valid_i(adc_valid_i),
        .adc_data_i(adc_data_i), .offset_load_i(offset_load_i),
        .offset_val_i(offset_val_i), .cmd_ready_o(cmd_ready_o),
        .cmd_done_o(cmd_done_o), .cmd_refused_o(cmd_refused_o),
        .reading_valid_o(reading_valid_o),
        .reading_text_o(reading_text_o), .overload_o(overload_o)
    );

    host_model host (
        .clock_i(clock_i), .cmd_ready_i(cmd_ready_o),
        .cmd_done_i(cmd_done_o), .cmd_refused_i(cmd_refused_o),
        .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
        .cmd_index_o(cmd_index_i), .cmd_arg_neg_o(cmd_arg_neg_i),
        .cmd_arg_bcd_o(cmd_arg_bcd_i), .adc_valid_o(adc_valid_i),
        .adc_data_o(adc_data_i)
    );

    always #10 clock_i = ~clock_i;

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Hundredths to sign, five digits, point, two digits
    function automatic logic [71:0] fmt(input int v);
        int a;
        int p;
        logic [71:0] t;
        a = (v < 0) ? -v : v;
        t[71:64] = (v < 0) ? 8'h2D : 8'h2B;
        t[23:16] = 8'h2E;
        for (int k = 0; k < 7; k++)
        begin
            p = (k < 2) ? k : k + 1;
            t[p*8 +: 8] = 8'h30 + 8'(a % 10);
            a = a / 10;
        end
        return t;
    endfunction : fmt

    task automatic cmd(input logic [2:0] c, input logic [4:0] i,
        input logic n, input logic [27:0] b, input logic er);
        int cyc;
        logic r;
        host.send(c, i, n, b, cyc, r);
        chk(72'(r), 72'(er));
        chk(72'(cyc), (!er && c >= 3'h1 && c <= 3'h3) ? 72'h8 : 72'h1);
    endtask : cmd

    task automatic pt(input logic [2:0] c, input logic [4:0] i,
        input logic [14:0] x, input logic n, input logic [27:0] b);
        host.sample(x);
        cmd(3'h0, 5'h00, 1'b0, 28'h0000000, 1'b0);
        cmd(c, i, n, b, 1'b0);
    endtask : pt

    // Drain any reading launched by an earlier sample first
    task automatic rd(input logic [14:0] x, input int y, input logic ov);
        int k;
        repeat (150) @(posedge clock_i);
        host.sample(x);
        k = 0;
        do
        begin
            @(posedge clock_i);
            k++;
        end
        while (reading_valid_o !== 1'b1 && k < 300);
        chk(72'(reading_valid_o), 72'h1);
        chk(reading_text_o, fmt(y));
        chk(72'(overload_o), 72'(ov));
    endtask : rd

    task automatic t_reset;
        @(posedge clock_i);
        chk(72'(cmd_ready_o), 72'h1);
        chk(reading_text_o, fmt(0));
        chk(72'(overload_o), 72'h0);
        rd(15'h4000, 16384, 1'b0);
        rd(15'h7FFF, 32767, 1'b0);
    endtask : t_reset

    task automatic t_refuse;
        cmd(3'h1, 5'h00, 1'b0, 28'h0000000, 1'b1);
        for (int c = 6; c < 8; c++)
        begin
            cmd(3'h0, 5'h00, 1'b0, 28'h0000000, 1'b0);
            cmd(3'(c), 5'h00, 1'b0, 28'h0000000, 1'b1);
        end
        cmd(3'h0, 5'h00, 1'b0, 28'h0000000, 1'b0);
        cmd(3'h3, 5'h17, 1'b0, 28'h0000100, 1'b1);
        cmd(3'h4, 5'h00, 1'b0, 28'h0000000, 1'b1);
        rd(15'h4000, 16384, 1'b0);
    endtask : t_refuse

    task automatic t_linear;
        cmd(3'h0, 5'h00, 1'b0, 28'h0000000, 1'b0);
        cmd(3'h4, 5'h00, 1'b0, 28'h0000000, 1'b0);
        cmd(3'h0, 5'h00, 1'b0, 28'h0000000, 1'b0);
        cmd(3'h5, 5'h00, 1'b0, 28'h0000000, 1'b0);
        pt(3'h1, 5'h00, 15'h03E8, 1'b1, 28'h0010000);
        rd(15'h01F4, -9999999, 1'b1);
        pt(3'h2, 5'h00, 15'h0BB8, 1'b0, 28'h0010000);
        rd(15'h0FA0, 9999999, 1'b1);
        rd(15'h07D0, 0, 1'b0);
        rd(15'h05DC, -5000, 1'b0);
    endtask : t_linear

    task automatic t_overwrite;
        pt(3'h2, 5'h00, 15'h0BB8, 1'b0, 28'h0030000);
        rd(15'h07D0, 10000, 1'b0);
    endtask : t_overwrite

    task automatic t_segment;
        pt(3'h3, 5'h00, 15'h09C4, 1'b0, 28'h0050000);
        rd(15'h08CA, 40000, 1'b0);
        rd(15'h06D6, 20000, 1'b0);
    endtask : t_segment

    task automatic t_erase;
        cmd(3'h0, 5'h00, 1'b0, 28'h0000000, 1'b0);
        cmd(3'h4, 5'h00, 1'b0, 28'h0000000, 1'b0);
        rd(15'h08CA, 15000, 1'b0);
        rd(15'h01F4, -9999999, 1'b1);
    endtask : t_erase

    task automatic t_offset;
        @(posedge clock_i);
        offset_load_i <= 1'b1;
        offset_val_i <= 25'h0002710;
        @(posedge clock_i);
        offset_load_i <= 1'b0;
        rd(15'h08CA, 25000, 1'b0);
        cmd(3'h0, 5'h00, 1'b0, 28'h0000000, 1'b0);
        cmd(3'h5, 5'h00, 1'b0, 28'h0000000, 1'b0);
        rd(15'h08CA, 15000, 1'b0);
    endtask : t_offset

    initial
    begin
        repeat (30000) @(posedge clock_i);
        num_errors++;
        end_of_test;
    end

    initial
    begin
        sys_rst_i = 1'b1;
        offset_load_i = 1'b0;
        offset_val_i = 25'h0000000;
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_reset;
        t_refuse;
        t_linear;
        t_overwrite;
        t_segment;
        t_erase;
        t_offset;
        end_of_test;
    end
endmodule : transfer_function_programmer_tb_top

`default_nettype wire
